// ---- epirq_filter.sv ----
// epirq_filter: three-sample agreement noise filter for one channel
// assumes input already synchronous; o_level follows input when bypassed
`timescale 1ns/10ps
module epirq_filter
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in,
  input wire logic i_enable,
  input wire logic i_tick,
  output logic o_level
);
  logic [1:0] hist;
  logic [1:0] next_hist;
  logic next_level;

  always_comb
  begin
    next_hist = hist;
    next_level = o_level;
    if (!i_enable)
    begin
      next_hist = {i_in, i_in};
      next_level = i_in;
    end
    else if (i_tick)
    begin
      next_hist = {hist[0], i_in};
      if (hist[1] == i_in && hist[0] == i_in)
      begin
        next_level = i_in;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      hist <= 2'b11;
      o_level <= 1'b1;
    end
    else
    begin
      hist <= next_hist;
      o_level <= next_level;
    end
  end
endmodule : epirq_filter

// ---- epirq_pin_src.sv ----
// epirq_pin_src: external interrupt sources on the pins
// assumes pull-ups hold pins high; caller sets pins right after an edge
`timescale 1ns/10ps
module epirq_pin_src
(
  input wire logic i_core_clk,
  output logic [15:0] o_pin
);
  initial o_pin = 16'hffff;
  task automatic set_pins(input logic [15:0] v);
    o_pin <= v;
  endtask : set_pins
endmodule : epirq_pin_src

// ---- epirq_pkg.sv ----
// epirq_pkg: constants for the external pin interrupt detect and filter block
// assumes a single 40 MHz peripheral bus clock and a plain register port
package epirq_pkg;
  localparam int unsigned EPIRQ_NCH = 8;
  localparam int unsigned EPIRQ_NPIN = 16;
  localparam int unsigned EPIRQ_PSEL_W = 5;
  localparam int unsigned EPIRQ_ADDR_W = 8;
  localparam int unsigned EPIRQ_DATA_W = 32;
  localparam int unsigned EPIRQ_CLK_MHZ = 40;
  // register offsets (byte addresses)
  localparam logic [7:0] EPIRQ_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] EPIRQ_OFS_CTRL7 = 8'h1c;
  localparam logic [7:0] EPIRQ_OFS_STATUS = 8'h20;
  localparam logic [7:0] EPIRQ_OFS_CLEAR = 8'h24;
  localparam logic [7:0] EPIRQ_OFS_ENABLE = 8'h28;
  localparam logic [7:0] EPIRQ_OFS_LEVEL = 8'h2c;
  localparam logic [7:0] EPIRQ_OFS_PIN0 = 8'h40;
  localparam logic [7:0] EPIRQ_OFS_PIN15 = 8'h7c;
  // channel control fields
  localparam int unsigned EPIRQ_F_MODE_LSB = 0;
  localparam int unsigned EPIRQ_F_RATE_LSB = 4;
  localparam int unsigned EPIRQ_F_FILTER_ENABLE = 7;
  localparam logic [7:0] EPIRQ_CTRL_RST = 8'h00;
  // pin function fields
  localparam int unsigned EPIRQ_F_PSEL_LSB = 0;
  localparam int unsigned EPIRQ_F_ROUTE = 8;
  localparam int unsigned EPIRQ_F_CHAN_LSB = 12;
  localparam logic [15:0] EPIRQ_PIN_RST = 16'h0000;
  // divider ratios and filter length
  localparam logic [5:0] EPIRQ_DIV8_M1 = 6'd7;
  localparam logic [5:0] EPIRQ_DIV32_M1 = 6'd31;
  localparam logic [5:0] EPIRQ_DIV64_M1 = 6'd63;
  localparam int unsigned EPIRQ_FLT_SAMPLES = 3;
  localparam logic [31:0] EPIRQ_RDZERO = 32'h0000_0000;

  typedef enum logic [1:0]
  {
    EPIRQ_TRIG_LOW = 2'b00,
    EPIRQ_TRIG_FALL = 2'b01,
    EPIRQ_TRIG_RISE = 2'b10,
    EPIRQ_TRIG_BOTH = 2'b11
  } epirq_trig_t;

  typedef enum logic [1:0]
  {
    EPIRQ_RATE_DIV1 = 2'b00,
    EPIRQ_RATE_DIV8 = 2'b01,
    EPIRQ_RATE_DIV32 = 2'b10,
    EPIRQ_RATE_DIV64 = 2'b11
  } epirq_rate_t;
endpackage : epirq_pkg

// ---- epirq_rate_gen.sv ----
// epirq_rate_gen: one-cycle sample enables at clock, /8, /32 and /64
// assumes one free-running clock with synchronous reset
`timescale 1ns/10ps
module epirq_rate_gen
  import epirq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  output logic [3:0] o_tick
);
  import epirq_pkg::*;

  logic [5:0] div_cnt;
  logic [5:0] next_div_cnt;
  logic [3:0] next_tick;

  always_comb
  begin
    next_div_cnt = (div_cnt == EPIRQ_DIV64_M1) ? 6'd0 : div_cnt + 6'd1;
    next_tick[EPIRQ_RATE_DIV1] = 1'b1;
    next_tick[EPIRQ_RATE_DIV8] = (div_cnt[2:0] == EPIRQ_DIV8_M1[2:0]);
    next_tick[EPIRQ_RATE_DIV32] = (div_cnt[4:0] == EPIRQ_DIV32_M1[4:0]);
    next_tick[EPIRQ_RATE_DIV64] = (div_cnt == EPIRQ_DIV64_M1);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      div_cnt <= 6'd0;
      o_tick <= 4'h0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      o_tick <= next_tick;
    end
  end
endmodule : epirq_rate_gen

// ---- epirq_top.sv ----
// epirq_top: external pin interrupt routing, filtering and detection
// assumes synchronous pins and register port; one 40 MHz clock
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module epirq_top
  import epirq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [EPIRQ_NPIN-1:0] i_pin,
  input wire logic [EPIRQ_ADDR_W-1:0] i_addr,
  input wire logic [EPIRQ_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [EPIRQ_DATA_W-1:0] o_rdata,
  output logic [EPIRQ_NCH-1:0] o_chan_req,
  output logic [EPIRQ_NCH-1:0] o_chan_level,
  output logic [EPIRQ_NPIN*EPIRQ_PSEL_W-1:0] o_pin_func,
  output logic o_irq
);
  import epirq_pkg::*;

  function automatic logic [EPIRQ_DATA_W-1:0] epirq_zext8(input logic [7:0] v);
    epirq_zext8 = {24'h000000, v};
  endfunction : epirq_zext8

  logic [7:0] chan_ctrl [EPIRQ_NCH];
  logic [7:0] next_chan_ctrl [EPIRQ_NCH];
  logic [15:0] pin_function_reg [EPIRQ_NPIN];
  logic [15:0] next_pin_function_reg [EPIRQ_NPIN];
  logic [EPIRQ_NCH-1:0] irq_status;
  logic [EPIRQ_NCH-1:0] next_irq_status;
  logic [EPIRQ_NCH-1:0] irq_enable;
  logic [EPIRQ_NCH-1:0] next_irq_enable;
  logic [EPIRQ_DATA_W-1:0] next_rdata;
  logic [EPIRQ_NCH-1:0] chan_raw;
  logic [EPIRQ_NCH-1:0] filt_level;
  logic [EPIRQ_NCH-1:0] prev_level;
  logic [EPIRQ_NCH-1:0] next_req;
  logic [EPIRQ_NPIN*EPIRQ_PSEL_W-1:0] next_pin_func;
  logic [3:0] tick;
  logic [EPIRQ_NPIN-1:0] irq_input_route;
  logic [2:0] pin_chan [EPIRQ_NPIN];

  epirq_rate_gen u_rate
  (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  // per-pin routing fields
  genvar gp;
  generate
    for (gp = 0; gp < EPIRQ_NPIN; gp++)
    begin : g_pin
      assign irq_input_route[gp] = pin_function_reg[gp][EPIRQ_F_ROUTE];
      assign pin_chan[gp] = pin_function_reg[gp][EPIRQ_F_CHAN_LSB +: 3];
      // peripheral select stays live whatever the route bit
      assign next_pin_func[gp*EPIRQ_PSEL_W +: EPIRQ_PSEL_W] =
        pin_function_reg[gp][EPIRQ_F_PSEL_LSB +: EPIRQ_PSEL_W];
    end
  endgenerate

  // pins whose channel field names channel ch
  function automatic logic [EPIRQ_NPIN-1:0] route_mask(input logic [2:0] ch);
    logic [EPIRQ_NPIN-1:0] m;
    m = '0;
    for (int p = 0; p < EPIRQ_NPIN; p++)
    begin
      m[p] = (pin_chan[p] == ch);
    end
    route_mask = m;
  endfunction : route_mask

  // channel input mux; more than one routed pin is ORed
  always_comb
  begin
    chan_raw = '0;
    for (int p = 0; p < EPIRQ_NPIN; p++)
    begin
      if (irq_input_route[p])
      begin
        chan_raw[pin_chan[p]] = chan_raw[pin_chan[p]] | i_pin[p];
      end
    end
    for (int c = 0; c < EPIRQ_NCH; c++)
    begin
      // unrouted channel idles high so nothing triggers
      if (!(|(irq_input_route & route_mask(c[2:0]))))
      begin
        chan_raw[c] = 1'b1;
      end
    end
  end

  // per-channel filter and detector
  genvar gc;
  generate
    for (gc = 0; gc < EPIRQ_NCH; gc++)
    begin : g_chan
      epirq_filter u_flt
      (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_in(chan_raw[gc]),
        .i_enable(chan_ctrl[gc][EPIRQ_F_FILTER_ENABLE]),
        .i_tick(tick[chan_ctrl[gc][EPIRQ_F_RATE_LSB +: 2]]),
        .o_level(filt_level[gc])
      );

      always_comb
      begin
        unique case (epirq_trig_t'(chan_ctrl[gc][EPIRQ_F_MODE_LSB +: 2]))
          EPIRQ_TRIG_LOW: next_req[gc] = ~filt_level[gc];
          EPIRQ_TRIG_FALL: next_req[gc] = prev_level[gc] & ~filt_level[gc];
          EPIRQ_TRIG_RISE: next_req[gc] = ~prev_level[gc] & filt_level[gc];
          EPIRQ_TRIG_BOTH: next_req[gc] = prev_level[gc] ^ filt_level[gc];
        endcase
      end
    end
  endgenerate

  // register write path and sticky status
  always_comb
  begin
    for (int c = 0; c < EPIRQ_NCH; c++)
    begin
      next_chan_ctrl[c] = chan_ctrl[c];
      if (i_wr && i_addr == EPIRQ_OFS_CTRL0 + 8'(c * 4))
      begin
        next_chan_ctrl[c] = i_wdata[7:0] & 8'hb3;
      end
    end
    for (int p = 0; p < EPIRQ_NPIN; p++)
    begin
      next_pin_function_reg[p] = pin_function_reg[p];
      if (i_wr && i_addr == EPIRQ_OFS_PIN0 + 8'(p * 4))
      begin
        next_pin_function_reg[p] = i_wdata[15:0] & 16'h711f;
      end
    end
    next_irq_enable = irq_enable;
    if (i_wr && i_addr == EPIRQ_OFS_ENABLE)
    begin
      next_irq_enable = i_wdata[EPIRQ_NCH-1:0];
    end
    next_irq_status = irq_status;
    if (i_wr && i_addr == EPIRQ_OFS_CLEAR)
    begin
      next_irq_status = irq_status & ~i_wdata[EPIRQ_NCH-1:0];
    end
    // set wins over a clear in the same cycle
    next_irq_status = next_irq_status | next_req;
  end

  // read path, data one cycle after the strobe
  always_comb
  begin
    next_rdata = EPIRQ_RDZERO;
    if (i_rd)
    begin
      if (i_addr >= EPIRQ_OFS_CTRL0 && i_addr <= EPIRQ_OFS_CTRL7 && i_addr[1:0] == 2'b00)
      begin
        next_rdata = epirq_zext8(chan_ctrl[i_addr[4:2]]);
      end
      else if (i_addr >= EPIRQ_OFS_PIN0 && i_addr <= EPIRQ_OFS_PIN15 && i_addr[1:0] == 2'b00)
      begin
        next_rdata = {16'h0000, pin_function_reg[i_addr[5:2]]};
      end
      else if (i_addr == EPIRQ_OFS_STATUS)
      begin
        next_rdata = epirq_zext8(irq_status);
      end
      else if (i_addr == EPIRQ_OFS_ENABLE)
      begin
        next_rdata = epirq_zext8(irq_enable);
      end
      else if (i_addr == EPIRQ_OFS_LEVEL)
      begin
        next_rdata = epirq_zext8(filt_level);
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      for (int c = 0; c < EPIRQ_NCH; c++)
      begin
        chan_ctrl[c] <= EPIRQ_CTRL_RST;
      end
      for (int p = 0; p < EPIRQ_NPIN; p++)
      begin
        pin_function_reg[p] <= EPIRQ_PIN_RST;
      end
      irq_status <= '0;
      irq_enable <= '0;
      prev_level <= '1;
      o_rdata <= EPIRQ_RDZERO;
      o_chan_req <= '0;
      o_chan_level <= '1;
      o_pin_func <= '0;
      o_irq <= 1'b0;
    end
    else
    begin
      chan_ctrl <= next_chan_ctrl;
      pin_function_reg <= next_pin_function_reg;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      prev_level <= filt_level;
      o_rdata <= next_rdata;
      o_chan_req <= next_req;
      o_chan_level <= filt_level;
      o_pin_func <= next_pin_func;
      o_irq <= |(next_irq_status & next_irq_enable);
    end
  end
endmodule : epirq_top

// ---- epirq_top_monitor.sv ----
// epirq_top_monitor: port checks for the pin interrupt block
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
module epirq_top_monitor
  import epirq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [EPIRQ_NPIN-1:0] i_pin,
  input wire logic [EPIRQ_ADDR_W-1:0] i_addr,
  input wire logic [EPIRQ_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [EPIRQ_DATA_W-1:0] o_rdata,
  input wire logic [EPIRQ_NCH-1:0] o_chan_req,
  input wire logic [EPIRQ_NCH-1:0] o_chan_level,
  input wire logic [EPIRQ_NPIN*EPIRQ_PSEL_W-1:0] o_pin_func,
  input wire logic o_irq
);
  logic [8:0] quiet;
  logic [8:0] next_quiet;
  logic [EPIRQ_NPIN-1:0] pin_d;
  default clocking dcb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // cycles since last pin change or write
  always_comb
  begin
    next_quiet = (i_pin != pin_d || i_wr) ? 9'h000 : quiet + {8'h00, quiet != 9'h1ff};
  end
  always_ff @(posedge i_core_clk)
  begin
    pin_d <= i_pin;
    quiet <= i_rst ? 9'h000 : next_quiet;
  end
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read slot");
  a_req_cause: assert property ((o_chan_req & o_chan_level & $past(o_chan_level)) == '0)
    else $error("request without edge or low level");
  a_func_write: assert property ($changed(o_pin_func) |-> $past(i_wr, 2))
    else $error("pin function changed without write");
  a_irq_rise: assert property ($rose(o_irq) |-> (|o_chan_req) || $past(|o_chan_req) || $past(i_wr) || $past(i_wr, 2))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2))
    else $error("interrupt fell without write");
  a_quiet_level: assert property (quiet[8] |-> $stable(o_chan_level))
    else $error("level moved with pins steady");
  a_quiet_req: assert property (quiet[8] |-> (o_chan_req & o_chan_level) == '0)
    else $error("edge request with pins steady");
  a_level_reset: assert property ($fell(i_rst) |-> o_chan_level == '1)
    else $error("channel level not idle high after reset");
  c_req: cover property (|o_chan_req);
  c_irq: cover property (o_irq);
  c_read: cover property ($past(i_rd) && o_rdata != '0);
endmodule : epirq_top_monitor

bind epirq_top epirq_top_monitor u_mon (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_pin(i_pin), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_chan_req(o_chan_req),
  .o_chan_level(o_chan_level), .o_pin_func(o_pin_func), .o_irq(o_irq));

// ---- tb_epirq_top.sv ----
// tb_epirq_top: register and pin scenarios for the pin interrupt block
// assumes epirq_pin_src drives pins; checker is bound separately
`timescale 1ns/10ps
module tb_epirq_top;
  import epirq_pkg::*;
  logic i_core_clk;
  logic i_rst;
  logic [EPIRQ_ADDR_W-1:0] i_addr;
  logic [EPIRQ_DATA_W-1:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [EPIRQ_NPIN-1:0] pin;
  logic [EPIRQ_DATA_W-1:0] o_rdata;
  logic [EPIRQ_NCH-1:0] o_chan_req;
  logic [EPIRQ_NCH-1:0] o_chan_level;
  logic [EPIRQ_NPIN*EPIRQ_PSEL_W-1:0] o_pin_func;
  logic o_irq;
  int mismatches;
  int cmp_count;
  int cycles;
  int nreq;
  int d;
  int exp_req[4] = '{20, 1, 1, 2};
  int rate_div[4] = '{1, 8, 32, 64};
  epirq_pin_src u_src (.i_core_clk(i_core_clk), .o_pin(pin));
  epirq_top u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_pin(pin), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_chan_req(o_chan_req), .o_chan_level(o_chan_level),
    .o_pin_func(o_pin_func), .o_irq(o_irq));
  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (o_chan_req[2] === 1'b1)
      nreq++;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rd
  task automatic pulse(input logic [15:0] m, input int n, input int w);
    u_src.set_pins(~m);
    cyc(n);
    u_src.set_pins(16'hffff);
    cyc(w);
  endtask : pulse
  initial
  begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    cyc(12);
    i_rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h30, 32'h0);
    wr(8'h4c, 32'h210a);
    rd(8'h4c, 32'h210a);
    chk(o_pin_func[19:15], 5'h0a);
    wr(8'h28, 32'hff);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h08, 32'(m));
      wr(8'h24, 32'hff);
      nreq = 0;
      pulse(16'h0008, 20, 10);
      chk(nreq, exp_req[m]);
      rd(8'h20, 32'h4);
      chk(o_irq, 1'b1);
    end
    wr(8'h4c, 32'h200a);
    nreq = 0;
    pulse(16'h0008, 20, 10);
    chk(nreq, 0);
    chk(o_chan_level[2], 1'b1);
    wr(8'h4c, 32'h210a);
    wr(8'h28, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h24, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      d = rate_div[r];
      wr(8'h08, 32'h81 | 32'(r << 4));
      nreq = 0;
      pulse(16'h0008, 2 * d - 1, 4 * d + 8);
      u_src.set_pins(16'hfff7);
      cyc(2);
      #1;
      chk(o_chan_level[2], 1'b1);
      cyc(4 * d);
      u_src.set_pins(16'hffff);
      cyc(4 * d + 8);
      chk(nreq, 1);
    end
    rd(8'h20, 32'h4);
    chk(o_irq, 1'b0);
    wr(8'h24, 32'hff);
    wr(8'h4c, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h40 + 8'(4 * c), 32'h100 | 32'(c << 12));
      wr(8'(4 * c), 32'(c % 4) | (c == 0 ? 32'hb0 : 32'h0));
    end
    u_src.set_pins(16'hff00);
    cyc(6);
    rd(8'h20, 32'hba);
    u_src.set_pins(16'hffff);
    cyc(6);
    rd(8'h20, 32'hfe);
    rd(8'h2c, 32'hff);
    report_and_stop();
  end
endmodule : tb_epirq_top
